// [hw/pmx_pkg.sv]
`default_nettype none
package pmx_pkg;
    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_A_DATA = 8'h0C;
    localparam logic [7:0] IDX_A_SEL2 = 8'h0D;
    localparam logic [7:0] IDX_A_DIR = 8'h0E;
    localparam logic [7:0] IDX_A_SEL = 8'h0F;
    localparam logic [7:0] IDX_B_DATA = 8'h10;
    localparam logic [7:0] IDX_B_SEL2 = 8'h11;
    localparam logic [7:0] IDX_B_DIR = 8'h12;
    localparam logic [7:0] IDX_B_SEL = 8'h20;
    localparam logic [7:0] IDX_ODE = 8'h21;
    localparam logic [3:0] LATCH_RST = 4'hF;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [2:0] ODE_RST = 3'h0;
    localparam logic [3:0] SEL2_A_MASK = 4'h3;
    localparam logic [3:0] SEL2_B_MASK = 4'hB;
    localparam int ODE_A0 = 0;
    localparam int ODE_A1 = 1;
    localparam int ODE_TX = 2;
    localparam int RX_PIN = 2;
    localparam int SHIFT_PIN = 3;
    typedef enum logic [2:0] {MODE_IN, MODE_OUT, MODE_CAP, MODE_TMR, MODE_SBUS,
                              MODE_ALT, MODE_RSV} pmx_mode_type;
    typedef struct packed {
        logic [3:0] dout;
        logic [3:0] oe;
        logic [3:0] pull;
    } pmx_pad_type;
endpackage : pmx_pkg
`default_nettype wire

// [hw/pmx_port_mux.sv]
`timescale 1ns/1ps
`default_nettype none
module pmx_port_mux (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [3:0] PA_IN,
    output logic [3:0] PA_OUT,
    output logic [3:0] PA_OE,
    input wire logic [3:0] PB_IN,
    output logic [3:0] PB_OUT,
    output logic [3:0] PB_OE,
    output logic [3:0] PB_PULLUP,
    output logic EXT_IRQ_A,
    output logic EXT_IRQ_B,
    output logic TIMER_CAPTURE_IN_A,
    output logic TIMER_CAPTURE_IN_B,
    input wire logic TIMER_OUT_A,
    input wire logic TIMER_OUT_B,
    input wire logic SERIAL_BUS_DATA_OUT,
    input wire logic SERIAL_BUS_CLOCK_OUT,
    output logic SERIAL_BUS_DATA_IN,
    output logic SERIAL_BUS_CLOCK_IN,
    input wire logic SYSTEM_CLOCK_OUT,
    input wire logic SERIAL_TX_DATA,
    input wire logic SERIAL_SHIFT_CLOCK_OUT,
    output logic SERIAL_RX_DATA,
    output logic SERIAL_SHIFT_CLOCK_IN,
    output logic SERIAL_CLEAR_TO_SEND
);
    // byte address match for a register index
    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] idx);
        is_reg = (a == {idx[5:0], 2'h0});
    endfunction : is_reg

    // port a decode on {second select, select, direction}
    function automatic pmx_pkg::pmx_mode_type a_mode(input logic [2:0] code, input int idx);
        case (code)
            3'h0: a_mode = pmx_pkg::MODE_IN;
            3'h1: a_mode = pmx_pkg::MODE_OUT;
            3'h2: a_mode = (idx < 2) ? pmx_pkg::MODE_CAP : pmx_pkg::MODE_RSV;
            3'h3: a_mode = (idx >= 2) ? pmx_pkg::MODE_TMR : pmx_pkg::MODE_RSV;
            3'h5: a_mode = (idx < 2) ? pmx_pkg::MODE_SBUS : pmx_pkg::MODE_RSV;
            default: a_mode = pmx_pkg::MODE_RSV;
        endcase
    endfunction : a_mode

    // port b decode on {second select, select, direction}
    function automatic pmx_pkg::pmx_mode_type b_mode(input logic [2:0] code, input int idx);
        case ({code[2], code[0]})
            2'h0: b_mode = pmx_pkg::MODE_IN;
            2'h1: b_mode = pmx_pkg::MODE_OUT;
            2'h3: b_mode = (code[1] && idx != pmx_pkg::RX_PIN) ? pmx_pkg::MODE_ALT
                                                               : pmx_pkg::MODE_RSV;
            default: b_mode = pmx_pkg::MODE_RSV;
        endcase
    endfunction : b_mode

    logic [3:0] latch_a;
    logic [3:0] sel2_a;
    logic [3:0] dir_a;
    logic [3:0] sel_a;
    logic [3:0] latch_b;
    logic [3:0] sel2_b;
    logic [3:0] dir_b;
    logic [3:0] sel_b;
    logic [2:0] open_drain_enable;
    logic [3:0] a_meta;
    logic [3:0] a_sync;
    logic [3:0] b_meta;
    logic [3:0] b_sync;
    logic wr;
    logic rd_setup;
    logic mapped;
    logic [31:0] next_rdata;
    pmx_pkg::pmx_mode_type mode_a [4];
    pmx_pkg::pmx_mode_type mode_b [4];
    pmx_pkg::pmx_pad_type next_a;
    pmx_pkg::pmx_pad_type next_b;
    logic [3:0] alt_a;
    logic [3:0] alt_b;
    logic [3:0] od_a;
    logic [3:0] od_b;

    // bus strobes; the slave never waits, so pready stays high
    assign wr = PSEL && PENABLE && PWRITE;
    assign rd_setup = PSEL && !PENABLE && !PWRITE;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;

    // pin inputs are asynchronous; meta flops feed only the sync flops
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            a_meta <= 4'h0;
            a_sync <= 4'h0;
            b_meta <= 4'h0;
            b_sync <= 4'h0;
        end
        else
        begin
            a_meta <= PA_IN;
            a_sync <= a_meta;
            b_meta <= PB_IN;
            b_sync <= b_meta;
        end
    end

    // output latches; only bits 3:0 exist
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            latch_a <= pmx_pkg::LATCH_RST;
            latch_b <= pmx_pkg::LATCH_RST;
        end
        else if (wr)
        begin
            if (is_reg(PADDR, pmx_pkg::IDX_A_DATA))
                latch_a <= PWDATA[3:0];
            if (is_reg(PADDR, pmx_pkg::IDX_B_DATA))
                latch_b <= PWDATA[3:0];
        end
    end

    // port a control; second select keeps only bits 1:0
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            dir_a <= pmx_pkg::CTRL_RST;
            sel_a <= pmx_pkg::CTRL_RST;
            sel2_a <= pmx_pkg::CTRL_RST;
        end
        else if (wr)
        begin
            if (is_reg(PADDR, pmx_pkg::IDX_A_DIR))
                dir_a <= PWDATA[3:0];
            if (is_reg(PADDR, pmx_pkg::IDX_A_SEL))
                sel_a <= PWDATA[3:0];
            if (is_reg(PADDR, pmx_pkg::IDX_A_SEL2))
                sel2_a <= PWDATA[3:0] & pmx_pkg::SEL2_A_MASK;
        end
    end

    // port b control and open-drain enables; bit 2 of second select absent
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            dir_b <= pmx_pkg::CTRL_RST;
            sel_b <= pmx_pkg::CTRL_RST;
            sel2_b <= pmx_pkg::CTRL_RST;
            open_drain_enable <= pmx_pkg::ODE_RST;
        end
        else if (wr)
        begin
            if (is_reg(PADDR, pmx_pkg::IDX_B_DIR))
                dir_b <= PWDATA[3:0];
            if (is_reg(PADDR, pmx_pkg::IDX_B_SEL))
                sel_b <= PWDATA[3:0];
            if (is_reg(PADDR, pmx_pkg::IDX_B_SEL2))
                sel2_b <= PWDATA[3:0] & pmx_pkg::SEL2_B_MASK;
            if (is_reg(PADDR, pmx_pkg::IDX_ODE))
                open_drain_enable <= PWDATA[2:0];
        end
    end

    // read mux; control registers are write-only and read as zero
    always_comb
    begin
        mapped = 1'b1;
        next_rdata = 32'h0000_0000;
        if (is_reg(PADDR, pmx_pkg::IDX_A_DATA))
            next_rdata = {28'h000_0000, a_sync};
        else if (is_reg(PADDR, pmx_pkg::IDX_B_DATA))
            next_rdata = {28'h000_0000, b_sync};
        else if (!(is_reg(PADDR, pmx_pkg::IDX_A_SEL2) || is_reg(PADDR, pmx_pkg::IDX_A_DIR)
                 || is_reg(PADDR, pmx_pkg::IDX_A_SEL) || is_reg(PADDR, pmx_pkg::IDX_B_SEL2)
                 || is_reg(PADDR, pmx_pkg::IDX_B_DIR) || is_reg(PADDR, pmx_pkg::IDX_B_SEL)
                 || is_reg(PADDR, pmx_pkg::IDX_ODE)))
            mapped = 1'b0;
    end

    // read data is captured in the setup cycle and held through access
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            PRDATA <= 32'h0000_0000;
        else if (rd_setup)
            PRDATA <= next_rdata;
    end

    // alternate sources and open-drain masks per pin
    assign alt_a = {TIMER_OUT_B, TIMER_OUT_A, SERIAL_BUS_CLOCK_OUT, SERIAL_BUS_DATA_OUT};
    assign alt_b = {SERIAL_SHIFT_CLOCK_OUT, 1'b0, SERIAL_TX_DATA, SYSTEM_CLOCK_OUT};
    assign od_a = {2'h0, open_drain_enable[pmx_pkg::ODE_A1], open_drain_enable[pmx_pkg::ODE_A0]};
    assign od_b = {2'h0, open_drain_enable[pmx_pkg::ODE_TX], 1'b0};

    // per-pin drive; open drain pulls low for a zero and floats for a one
    for (genvar i = 0; i < 4; i++)
    begin : g_pin
        logic va;
        logic vb;
        logic da;
        logic db;
        assign mode_a[i] = a_mode({sel2_a[i], sel_a[i], dir_a[i]}, i);
        assign mode_b[i] = b_mode({sel2_b[i], sel_b[i], dir_b[i]}, i);
        assign va = (mode_a[i] == pmx_pkg::MODE_OUT) ? latch_a[i] : alt_a[i];
        assign vb = (mode_b[i] == pmx_pkg::MODE_OUT) ? latch_b[i] : alt_b[i];
        assign da = (mode_a[i] == pmx_pkg::MODE_OUT) || (mode_a[i] == pmx_pkg::MODE_TMR)
                    || (mode_a[i] == pmx_pkg::MODE_SBUS);
        assign db = (mode_b[i] == pmx_pkg::MODE_OUT) || (mode_b[i] == pmx_pkg::MODE_ALT);
        assign next_a.oe[i] = da && (od_a[i] ? !va : 1'b1);
        assign next_a.dout[i] = va && !od_a[i];
        assign next_a.pull[i] = 1'b0;
        assign next_b.oe[i] = db && (od_b[i] ? !vb : 1'b1);
        assign next_b.dout[i] = vb && !od_b[i];
        assign next_b.pull[i] = !dir_b[i] && latch_b[i];
    end

    // pad outputs from flops; reset leaves every pin undriven
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            PA_OUT <= 4'h0;
            PA_OE <= 4'h0;
            PB_OUT <= 4'h0;
            PB_OE <= 4'h0;
            PB_PULLUP <= 4'hF;
        end
        else
        begin
            PA_OUT <= next_a.dout;
            PA_OE <= next_a.oe;
            PB_OUT <= next_b.dout;
            PB_OE <= next_b.oe;
            PB_PULLUP <= next_b.pull;
        end
    end

    // peripheral inputs; unselected ones idle, serial bus idles high, receive data always follows pin b2
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            EXT_IRQ_A <= 1'b0;
            EXT_IRQ_B <= 1'b0;
            TIMER_CAPTURE_IN_A <= 1'b0;
            TIMER_CAPTURE_IN_B <= 1'b0;
            SERIAL_BUS_DATA_IN <= 1'b1;
            SERIAL_BUS_CLOCK_IN <= 1'b1;
            SERIAL_RX_DATA <= 1'b1;
            SERIAL_SHIFT_CLOCK_IN <= 1'b0;
            SERIAL_CLEAR_TO_SEND <= 1'b0;
        end
        else
        begin
            EXT_IRQ_A <= (mode_a[0] == pmx_pkg::MODE_CAP) && a_sync[0];
            EXT_IRQ_B <= (mode_a[1] == pmx_pkg::MODE_CAP) && a_sync[1];
            TIMER_CAPTURE_IN_A <= (mode_a[0] == pmx_pkg::MODE_CAP) && a_sync[0];
            TIMER_CAPTURE_IN_B <= (mode_a[1] == pmx_pkg::MODE_CAP) && a_sync[1];
            SERIAL_BUS_DATA_IN <= (mode_a[0] != pmx_pkg::MODE_SBUS) || a_sync[0];
            SERIAL_BUS_CLOCK_IN <= (mode_a[1] != pmx_pkg::MODE_SBUS) || a_sync[1];
            SERIAL_RX_DATA <= b_sync[pmx_pkg::RX_PIN];
            SERIAL_SHIFT_CLOCK_IN <= (mode_b[pmx_pkg::SHIFT_PIN] == pmx_pkg::MODE_IN)
                                     && b_sync[pmx_pkg::SHIFT_PIN];
            SERIAL_CLEAR_TO_SEND <= (mode_b[pmx_pkg::SHIFT_PIN] == pmx_pkg::MODE_IN)
                                    && b_sync[pmx_pkg::SHIFT_PIN];
        end
    end

    // checks of the port behaviour
    AST_RST_STATE: assert property (@(posedge MCLK) $fell(RST) |->
        (latch_a == 4'hF) && (latch_b == 4'hF) && (dir_a == 4'h0) && (sel2_b == 4'h0))
        else $error("reset state of latches or control wrong");
    AST_A_INPUT_NODRIVE: assert property (@(posedge MCLK) disable iff (RST)
        (dir_a == 4'h0) |=> (PA_OE == 4'h0))
        else $error("port a drives while all inputs");
    AST_A_NO_ALT: assert property (@(posedge MCLK) disable iff (RST)
        (sel_a == 4'h0) |=> !EXT_IRQ_A && !EXT_IRQ_B && !TIMER_CAPTURE_IN_B)
        else $error("port a alternate input without select");
    AST_A_OD: assert property (@(posedge MCLK) disable iff (RST)
        open_drain_enable[0] && (mode_a[0] == pmx_pkg::MODE_OUT) |=> !PA_OUT[0] && (PA_OE[0] == !$past(latch_a[0])))
        else $error("port a pin 0 open drain wrong");
    AST_A_TMR: assert property (@(posedge MCLK) disable iff (RST)
        (mode_a[3] == pmx_pkg::MODE_TMR) |=> PA_OE[3] && (PA_OUT[3] == $past(TIMER_OUT_B)))
        else $error("timer output not on pin 3");
    AST_A_READ: assert property (@(posedge MCLK) disable iff (RST)
        rd_setup && is_reg(PADDR, pmx_pkg::IDX_A_DATA) |=> (PRDATA == {28'h000_0000, $past(a_sync)}))
        else $error("port a read not pin levels");
    AST_WO_ZERO: assert property (@(posedge MCLK) disable iff (RST)
        rd_setup && is_reg(PADDR, pmx_pkg::IDX_B_DIR) |=> (PRDATA == 32'h0000_0000))
        else $error("write-only register read nonzero");
    AST_UPPER_ZERO: assert property (@(posedge MCLK) disable iff (RST)
        rd_setup |=> (PRDATA[31:4] == 28'h000_0000))
        else $error("upper read bits nonzero");
    AST_B_PULL: assert property (@(posedge MCLK) disable iff (RST)
        !dir_b[0] |=> (PB_PULLUP[0] == $past(latch_b[0])) && !PB_OE[0])
        else $error("pull-up not from latch in input mode");
    AST_B_TX_OD: assert property (@(posedge MCLK) disable iff (RST)
        open_drain_enable[2] && (mode_b[1] == pmx_pkg::MODE_ALT) |=> !PB_OUT[1] && (PB_OE[1] == !$past(SERIAL_TX_DATA)))
        else $error("tx open drain wrong");
    AST_B_RX: assert property (@(posedge MCLK) disable iff (RST)
        ##1 1'b1 |-> SERIAL_RX_DATA == $past(PB_IN[2], 3))
        else $error("receive input not from pin 2");
    AST_B_SEL2_BIT2: assert property (@(posedge MCLK) disable iff (RST)
        !sel2_b[2] && !sel2_a[2])
        else $error("absent second select bit set");
    COV_SBUS: cover property (@(posedge MCLK) disable iff (RST) mode_a[0] == pmx_pkg::MODE_SBUS);
    COV_TX: cover property (@(posedge MCLK) disable iff (RST) mode_b[1] == pmx_pkg::MODE_ALT);
    COV_CAP: cover property (@(posedge MCLK) disable iff (RST) EXT_IRQ_B);
    COV_WR_LATCH: cover property (@(posedge MCLK) disable iff (RST)
        wr && is_reg(PADDR, pmx_pkg::IDX_B_DATA));
endmodule : pmx_port_mux
`default_nettype wire

// [bench/pmx_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
// pad ring seen from outside: external drivers, pull-ups and floating lines
module pmx_pin_model (
    input wire logic MCLK,
    input wire logic [3:0] PA_OUT,
    input wire logic [3:0] PA_OE,
    input wire logic [3:0] PB_OUT,
    input wire logic [3:0] PB_OE,
    input wire logic [3:0] PB_PULLUP,
    input wire logic [3:0] EXT_A,
    input wire logic [3:0] EXT_B,
    input wire logic [3:0] EXT_EN_B,
    output logic [3:0] PA_IN,
    output logic [3:0] PB_IN
);
    logic tog = 1'b0;

    // a floating line wanders so that a stale level never passes for a match
    always_ff @(posedge MCLK)
    begin
        tog <= ~tog;
    end

    // port a pins not driven by the device are always driven from outside
    assign PA_IN = (PA_OE & PA_OUT) | (~PA_OE & EXT_A);
    // the pull-up only shows where neither side drives the pin
    assign PB_IN = (PB_OE & PB_OUT) | (~PB_OE & EXT_EN_B & EXT_B)
        | (~PB_OE & ~EXT_EN_B & (PB_PULLUP | {4{tog}}));
endmodule : pmx_pin_model
`default_nettype wire

// [bench/pmx_port_mux_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t %s", $time, m); end end
module pmx_port_mux_tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, irq_a, irq_b, cap_a, cap_b, sbd_in, sbc_in, rxd, shc_in, cts;
    logic [3:0] pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, pb_pull, pa, pb;
    logic [6:0] pv = 7'h00;
    logic [3:0] ea = 4'h0;
    logic [3:0] eb = 4'h0;
    logic [3:0] eb_en = 4'hF;
    logic [31:0] w [9];
    logic [7:0] adr [9] = '{8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h44, 8'h48, 8'h80, 8'h84};
    logic [7:0] ro [9] = '{8'h34, 8'h38, 8'h3C, 8'h44, 8'h48, 8'h80, 8'h84, 8'h4C, 8'h31};
    logic [2:0] c0, c1;
    logic [31:0] rdum;
    logic edum;
    pmx_pkg::pmx_pad_type xa, xb;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;

    always #20 mclk = ~mclk;

    pmx_port_mux uut (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .PA_IN(pa_in), .PA_OUT(pa_out), .PA_OE(pa_oe), .PB_IN(pb_in), .PB_OUT(pb_out),
        .PB_OE(pb_oe), .PB_PULLUP(pb_pull), .EXT_IRQ_A(irq_a), .EXT_IRQ_B(irq_b),
        .TIMER_CAPTURE_IN_A(cap_a), .TIMER_CAPTURE_IN_B(cap_b), .TIMER_OUT_A(pv[0]),
        .TIMER_OUT_B(pv[1]), .SERIAL_BUS_DATA_OUT(pv[2]), .SERIAL_BUS_CLOCK_OUT(pv[3]),
        .SERIAL_BUS_DATA_IN(sbd_in), .SERIAL_BUS_CLOCK_IN(sbc_in), .SYSTEM_CLOCK_OUT(pv[4]),
        .SERIAL_TX_DATA(pv[5]), .SERIAL_SHIFT_CLOCK_OUT(pv[6]), .SERIAL_RX_DATA(rxd),
        .SERIAL_SHIFT_CLOCK_IN(shc_in), .SERIAL_CLEAR_TO_SEND(cts));

    pmx_pin_model pins (.MCLK(mclk), .PA_OUT(pa_out), .PA_OE(pa_oe), .PB_OUT(pb_out),
        .PB_OE(pb_oe), .PB_PULLUP(pb_pull), .EXT_A(ea), .EXT_B(eb), .EXT_EN_B(eb_en),
        .PA_IN(pa_in), .PB_IN(pb_in));

    // one apb transfer; the request holds until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // no wait-state count assumed; only the hang guard ends a stuck wait
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        `CHK(r, x, "read data")
        `CHK(e, xe, "error flag")
    endtask : rd_chk

    // expected port a drive; p[i^2] picks the timer or serial-bus source of pin i
    function automatic pmx_pkg::pmx_pad_type exp_a(input logic [31:0] v [9], logic [6:0] p);
        pmx_pkg::pmx_pad_type x;
        logic [2:0] c;
        logic dr;
        x = '0;
        for (int i = 0; i < 4; i++)
        begin
            c = {v[1][i] & (i < 2), v[3][i], v[2][i]};
            dr = (c == 3'b001) | (c == 3'b011 && i >= 2) | (c == 3'b101 && i < 2);
            x.dout[i] = (c == 3'b001) ? v[0][i] : p[i ^ 2];
            if (i < 2 && v[8][i]) dr = dr & ~x.dout[i];
            x.oe[i] = dr;
            x.dout[i] = dr & x.dout[i];
        end
        return x;
    endfunction : exp_a

    // expected port b drive; alternate use also needs the select bit
    function automatic pmx_pkg::pmx_pad_type exp_b(input logic [31:0] v [9], logic [6:0] p);
        pmx_pkg::pmx_pad_type x;
        logic [1:0] c;
        logic dr;
        x = '0;
        for (int i = 0; i < 4; i++)
        begin
            c = {v[5][i] & (i != 2), v[6][i]};
            dr = (c == 2'b01) | (c == 2'b11 && v[7][i]);
            x.dout[i] = (c == 2'b01) ? v[4][i] : p[(i == 3) ? 6 : i + 4];
            if (i == 1 && v[8][2]) dr = dr & ~x.dout[i];
            x.oe[i] = dr;
            x.dout[i] = dr & x.dout[i];
        end
        x.pull = ~v[6][3:0] & v[4][3:0];
        return x;
    endfunction : exp_b

    task stop_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    // hang guard, well above the roughly 1600 cycles the sequence needs
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    initial
    begin
        void'($urandom(7127));
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(negedge mclk);
        `CHK(pa_oe, 4'h0, "port a reset drive")
        `CHK(pb_oe, 4'h0, "port b reset drive")
        `CHK(pb_pull, 4'hF, "port b reset pull-up")
        foreach (ro[j]) rd_chk(ro[j], 32'h0000_0000, j >= 7);
        apb(1'b1, 8'h38, 32'h0000_000F, rdum, edum);
        apb(1'b1, 8'h48, 32'h0000_000F, rdum, edum);
        repeat (3) @(negedge mclk);
        `CHK(pa_out, 4'hF, "port a latch after reset")
        `CHK(pb_out, 4'hF, "port b latch after reset")
        apb(1'b1, 8'h48, 32'h0000_0000, rdum, edum);
        eb_en <= 4'h0;
        repeat (6) @(negedge mclk);
        rd_chk(8'h40, 32'h0000_000F, 1'b0);
        eb_en <= 4'hF;
        for (int k = 0; k < 40; k++)
        begin
            foreach (w[j]) w[j] = $urandom();
            if (k < 8)
            begin
                w[1][3:0] = {4{k[2]}};
                w[3][3:0] = {4{k[1]}};
                w[2][3:0] = {4{k[0]}};
                w[5][3:0] = {4{k[1]}};
                w[6][3:0] = {4{k[0]}};
                w[7][3:0] = {4{k[2]}};
            end
            // each register written whole, never read back first
            foreach (w[j]) apb(1'b1, adr[j], w[j], rdum, edum);
            pv <= 7'($urandom());
            ea <= 4'($urandom());
            eb <= 4'($urandom());
            repeat (6) @(negedge mclk);
            xa = exp_a(w, pv);
            xb = exp_b(w, pv);
            pa = (xa.oe & xa.dout) | (~xa.oe & ea);
            pb = (xb.oe & xb.dout) | (~xb.oe & eb);
            c0 = {w[1][0], w[3][0], w[2][0]};
            c1 = {w[1][1], w[3][1], w[2][1]};
            `CHK(pa_oe, xa.oe, "port a enable")
            `CHK(pa_out & pa_oe, xa.dout, "port a level")
            `CHK(pb_oe, xb.oe, "port b enable")
            `CHK(pb_out & pb_oe, xb.dout, "port b level")
            `CHK(pb_pull, xb.pull, "port b pull-up")
            `CHK({irq_a, cap_a}, {2{c0 == 3'b010 && pa[0]}}, "pin a0 capture")
            `CHK({irq_b, cap_b}, {2{c1 == 3'b010 && pa[1]}}, "pin a1 capture")
            `CHK(sbd_in, (c0 == 3'b101) ? pa[0] : 1'b1, "serial bus data in")
            `CHK(sbc_in, (c1 == 3'b101) ? pa[1] : 1'b1, "serial bus clock in")
            `CHK(rxd, pb[2], "receive data")
            `CHK({shc_in, cts}, {2{~w[5][3] & ~w[6][3] & pb[3]}}, "pin b3 in")
            rd_chk(8'h30, {28'h000_0000, pa}, 1'b0);
            rd_chk(8'h40, {28'h000_0000, pb}, 1'b0);
        end
        stop_test();
    end
endmodule : pmx_port_mux_tb
`default_nettype wire
